// ---- hdl/host_port_pkg.sv ----
// Shared constants and types of the host parallel port
package host_port_pkg;

  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int DATA_W = 8;
  localparam int SEL_W = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 2;
  localparam int COND_W = 8;

  // ****************************************************************
  // Register select codes
  // ****************************************************************
  localparam logic [SEL_W-1:0] SEL_INT = 3'h0;     // Read: condition status, write: mask
  localparam logic [SEL_W-1:0] SEL_STATUS = 3'h1;  // Read: port status, write: control
  localparam logic [SEL_W-1:0] SEL_DATA = 3'h7;    // Read: data in, write: command/data out

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTL_DMA_IN_BIT = 0;
  localparam int CTL_DMA_OUT_BIT = 1;
  localparam int STAT_FIFO_VALID_BIT = 0;
  localparam int STAT_FIFO_FULL_BIT = 1;
  localparam int STAT_CMD_OUT_FULL_BIT = 2;
  localparam int STAT_INT_BIT = 3;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CTL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // Host access sequencer states
  typedef enum logic [2:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE,
    ACC_DMA_READ,
    ACC_DMA_WRITE
  } acc_state_t;

endpackage : host_port_pkg

// ---- hdl/host_pins_if.sv ----
// Synchronised host pin levels passed from the synchroniser to the port logic
`timescale 1ns/1ns
`default_nettype none
interface host_pins_if;
  import host_port_pkg::*;
  logic chip_enable_n;
  logic read_direction_strobe;
  logic write_enable_n;
  logic dma_grant_n;
  logic [SEL_W-1:0] register_select;
  logic [DATA_W-1:0] data;

  modport src (
    output chip_enable_n, read_direction_strobe, write_enable_n, dma_grant_n,
    output register_select, data
  );
  modport dst (
    input chip_enable_n, read_direction_strobe, write_enable_n, dma_grant_n,
    input register_select, data
  );
endinterface : host_pins_if
`default_nettype wire

// ---- hdl/pin_sync.sv ----
// Two-stage synchroniser for all asynchronous host pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync
  import host_port_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_enable_n,
  input wire logic read_direction_strobe,
  input wire logic write_enable_n,
  input wire logic dma_grant_n,
  input wire logic [host_port_pkg::SEL_W-1:0] register_select,
  input wire logic [host_port_pkg::DATA_W-1:0] data_in,
  host_pins_if.src pins
);
  localparam int W = 4 + SEL_W + DATA_W;

  logic [W-1:0] raw;
  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  // Idle levels: strobes and grant inactive
  localparam logic [W-1:0] IDLE = {4'hb, {(SEL_W + DATA_W){1'b0}}};

  assign raw = {chip_enable_n, read_direction_strobe, write_enable_n, dma_grant_n,
                register_select, data_in};

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage1_r <= IDLE;
      stage2_r <= IDLE;
    end
    else
    begin
      stage1_r <= raw;
      stage2_r <= stage1_r;
    end
  end

  assign pins.chip_enable_n = stage2_r[W-1];
  assign pins.read_direction_strobe = stage2_r[W-2];
  assign pins.write_enable_n = stage2_r[W-3];
  assign pins.dma_grant_n = stage2_r[W-4];
  assign pins.register_select = stage2_r[SEL_W+DATA_W-1:DATA_W];
  assign pins.data = stage2_r[DATA_W-1:0];
endmodule : pin_sync
`default_nettype wire

// ---- hdl/byte_fifo.sv ----
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : byte_fifo
`default_nettype wire

// ---- hdl/host_port.sv ----
// Host parallel port: register access, DMA request/grant and open-drain interrupt
`timescale 1ns/1ns
`default_nettype none
module host_port
  import host_port_pkg::*;
#(
  parameter int FIFO_DEPTH_P = host_port_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_enable_n,
  input wire logic read_direction_strobe,
  input wire logic write_enable_n,
  input wire logic dma_grant_n,
  input wire logic [host_port_pkg::SEL_W-1:0] register_select,
  input wire logic [host_port_pkg::DATA_W-1:0] data_in,
  output logic [host_port_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  output logic dma_request_n,
  output logic int_n_out,
  output logic int_n_oe,
  input wire logic [host_port_pkg::COND_W-1:0] int_cond,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [host_port_pkg::DATA_W-1:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [host_port_pkg::DATA_W-1:0] tx_data
);
  import host_port_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  host_pins_if pins ();

  acc_state_t state_r;
  logic [SEL_W-1:0] sel_r;
  logic [DATA_W-1:0] hold_r;
  logic [DATA_W-1:0] mask_r;
  logic [DATA_W-1:0] ctl_r;
  logic [DATA_W-1:0] cmd_out_r;
  logic cmd_out_full_r;
  logic [DATA_W-1:0] data_out_r;
  logic data_oe_r;
  logic dma_request_n_r;
  logic int_n_oe_r;

  logic ce_act;
  logic we_act;
  logic grant_act;
  logic host_read;
  logic host_write;
  logic dma_read;
  logic dma_write;
  logic strobe_held;
  logic finish;
  logic fifo_valid;
  logic fifo_ready;
  logic fifo_pop;
  logic [DATA_W-1:0] fifo_data;
  logic [DATA_W-1:0] read_mux;
  logic [DATA_W-1:0] status_word;
  logic int_pending;
  logic cmd_out_load;
  logic want_in;
  logic want_out;

  // ****************************************************************
  // Pin synchroniser and receive FIFO
  // ****************************************************************

  // All host pins pass two flip-flops before any decode
  pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .chip_enable_n(chip_enable_n),
    .read_direction_strobe(read_direction_strobe),
    .write_enable_n(write_enable_n),
    .dma_grant_n(dma_grant_n),
    .register_select(register_select),
    .data_in(data_in),
    .pins(pins)
  );

  // Bytes from the link side wait here until the host or DMA reads them
  byte_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(rx_valid),
    .in_ready(fifo_ready),
    .in_data(rx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Back-pressure to the link side
  assign rx_ready = fifo_ready;

  // ****************************************************************
  // Strobe decode
  // ****************************************************************

  // Active levels of the synchronised pins
  assign ce_act = !pins.chip_enable_n;
  assign we_act = !pins.write_enable_n;
  assign grant_act = !pins.dma_grant_n;

  // Normal cycles need chip enable and no grant; reads also need a high read strobe
  assign host_read = ce_act && pins.read_direction_strobe && !we_act && !grant_act;
  assign host_write = ce_act && we_act && !grant_act;

  // DMA cycles: read strobe counts as a read while low
  assign dma_read = grant_act && !pins.read_direction_strobe && !we_act;
  assign dma_write = grant_act && we_act;

  // The strobe that opened the current access is still present
  always_comb
  begin
    strobe_held = 1'b0;
    unique case (state_r)
      ACC_IDLE: strobe_held = 1'b0;
      ACC_READ: strobe_held = host_read;
      ACC_WRITE: strobe_held = host_write;
      ACC_DMA_READ: strobe_held = dma_read;
      ACC_DMA_WRITE: strobe_held = dma_write;
    endcase
  end

  // Access ends in the first cycle its strobe is gone
  assign finish = (state_r != ACC_IDLE) && !strobe_held;

  // ****************************************************************
  // Access sequencer
  // ****************************************************************

  // Grant takes priority over a select-code access
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= ACC_IDLE;
    end
    else if (state_r == ACC_IDLE)
    begin
      if (dma_write)
      begin
        state_r <= ACC_DMA_WRITE;
      end
      else if (dma_read)
      begin
        state_r <= ACC_DMA_READ;
      end
      else if (host_write)
      begin
        state_r <= ACC_WRITE;
      end
      else if (host_read)
      begin
        state_r <= ACC_READ;
      end
    end
    else if (finish)
    begin
      state_r <= ACC_IDLE;
    end
  end

  // Select code is taken at the start of an access
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sel_r <= '0;
    end
    else if (state_r == ACC_IDLE)
    begin
      sel_r <= (dma_read || dma_write) ? SEL_DATA : pins.register_select;
    end
  end

  // Write data follows the bus while the write strobe is held
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hold_r <= DATA_RESET;
    end
    else if (host_write || dma_write)
    begin
      hold_r <= pins.data;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************

  // Mask and control commit when the write strobe is released
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mask_r <= MASK_RESET;
      ctl_r <= CTL_RESET;
    end
    else if (finish && state_r == ACC_WRITE)
    begin
      if (sel_r == SEL_INT)
      begin
        mask_r <= hold_r;
      end
      if (sel_r == SEL_STATUS)
      begin
        ctl_r <= hold_r;
      end
    end
  end

  // Command/data-out load, from a normal write or a DMA write
  assign cmd_out_load = finish && ((state_r == ACC_WRITE && sel_r == SEL_DATA) ||
                                   state_r == ACC_DMA_WRITE);

  // Command/data-out byte and its full flag; a new load wins over a drain
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cmd_out_r <= DATA_RESET;
      cmd_out_full_r <= 1'b0;
    end
    else if (cmd_out_load)
    begin
      cmd_out_r <= hold_r;
      cmd_out_full_r <= 1'b1;
    end
    else if (tx_ready && cmd_out_full_r)
    begin
      cmd_out_full_r <= 1'b0;
    end
  end

  assign tx_valid = cmd_out_full_r;
  assign tx_data = cmd_out_r;

  // ****************************************************************
  // Register reads
  // ****************************************************************

  // Port status word
  always_comb
  begin
    status_word = '0;
    status_word[STAT_FIFO_VALID_BIT] = fifo_valid;
    status_word[STAT_FIFO_FULL_BIT] = !fifo_ready;
    status_word[STAT_CMD_OUT_FULL_BIT] = cmd_out_full_r;
    status_word[STAT_INT_BIT] = int_pending;
  end

  // Read multiplexer; unmapped codes read as zero
  always_comb
  begin
    read_mux = '0;
    if (sel_r == SEL_INT)
    begin
      read_mux = int_cond;
    end
    else if (sel_r == SEL_STATUS)
    begin
      read_mux = status_word;
    end
    else if (sel_r == SEL_DATA)
    begin
      read_mux = fifo_valid ? fifo_data : '0;
    end
  end

  // Data-in byte leaves the FIFO when its read strobe ends
  assign fifo_pop = finish && fifo_valid && (state_r == ACC_DMA_READ ||
                    (state_r == ACC_READ && sel_r == SEL_DATA));

  // Host data bus drive, only while a read strobe is held
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_out_r <= DATA_RESET;
      data_oe_r <= 1'b0;
    end
    else if ((state_r == ACC_READ || state_r == ACC_DMA_READ) && strobe_held)
    begin
      data_out_r <= read_mux;
      data_oe_r <= 1'b1;
    end
    else
    begin
      data_out_r <= DATA_RESET;
      data_oe_r <= 1'b0;
    end
  end

  assign data_out = data_out_r;
  assign data_oe = data_oe_r;

  // ****************************************************************
  // DMA request
  // ****************************************************************

  // A byte waits to be read, or the output register has room
  assign want_in = ctl_r[CTL_DMA_IN_BIT] && fifo_valid;
  assign want_out = ctl_r[CTL_DMA_OUT_BIT] && !cmd_out_full_r;

  // Request drops while an access is in progress so one grant moves one byte
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dma_request_n_r <= 1'b1;
    end
    else
    begin
      dma_request_n_r <= !((want_in || want_out) && state_r == ACC_IDLE && !grant_act);
    end
  end

  assign dma_request_n = dma_request_n_r;

  // ****************************************************************
  // Interrupt
  // ****************************************************************

  // Any unmasked condition
  assign int_pending = |(int_cond & mask_r);

  // Open drain: enable pulls the line low, release lets the pull-up win
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      int_n_oe_r <= 1'b0;
    end
    else
    begin
      int_n_oe_r <= int_pending;
    end
  end

  // Driven level is always low; high comes only from the pull-up
  assign int_n_out = 1'b0;
  assign int_n_oe = int_n_oe_r;

endmodule : host_port
`default_nettype wire

// ---- verif/host_port_monitor.sv ----
// Pin-level assertions for the host parallel port
`timescale 1ns/1ns
`default_nettype none
module host_port_monitor
  import host_port_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_enable_n,
  input wire logic read_direction_strobe,
  input wire logic write_enable_n,
  input wire logic dma_grant_n,
  input wire logic [host_port_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic dma_request_n,
  input wire logic int_n_out,
  input wire logic int_n_oe,
  input wire logic [host_port_pkg::COND_W-1:0] int_cond,
  input wire logic tx_valid
);
  logic rd_pins;
  logic no_sel;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Read cycle on the pins: strobe sense flips while granted
  assign no_sel = chip_enable_n && dma_grant_n;
  assign rd_pins = (read_direction_strobe == dma_grant_n) && write_enable_n && !no_sel;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  reset_idle_a: assert property (disable iff (1'b0) reset [*3] |->
    !data_oe && dma_request_n && !int_n_oe && !tx_valid && data_out == 8'h00)
    else $error("outputs not idle during reset");
  int_drive_a: assert property (int_n_out == 1'b0)
    else $error("interrupt pin driven high");
  int_cause_a: assert property (int_n_oe |-> $past(|int_cond))
    else $error("interrupt without a condition");
  int_clear_a: assert property (!(|int_cond) [*2] |-> !int_n_oe)
    else $error("interrupt stays after conditions clear");
  no_select_a: assert property (no_sel [*5] |-> !data_oe)
    else $error("data driven without chip enable or grant");
  oe_cause_a: assert property ($rose(data_oe) |-> $past(rd_pins, 2))
    else $error("data driven without a read strobe");
  oe_drop_a: assert property (!rd_pins [*5] |-> !data_oe && data_out == 8'h00)
    else $error("data still driven after strobe release");
  req_grant_a: assert property (!dma_grant_n [*5] |-> dma_request_n)
    else $error("request held during grant");
  req_cause_a: assert property ($fell(dma_request_n) |-> dma_grant_n && $past(dma_grant_n))
    else $error("request raised while granted");

  cover property ($rose(data_oe) && !dma_grant_n);
  cover property ($fell(int_n_oe));
  cover property ($rose(tx_valid));
endmodule : host_port_monitor

bind host_port host_port_monitor mon (.*);
`default_nettype wire

// ---- verif/host_agent.sv ----
// Host CPU and DMA master model driving the port pins
`timescale 1ns/1ns
`default_nettype none
module host_agent
  import host_port_pkg::*;
(
  input wire logic clk,
  input wire logic [host_port_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  output logic chip_enable_n,
  output logic read_direction_strobe,
  output logic write_enable_n,
  output logic dma_grant_n,
  output logic [host_port_pkg::SEL_W-1:0] register_select,
  output logic [host_port_pkg::DATA_W-1:0] data_in
);
  // Idle pin levels
  initial
  begin
    chip_enable_n = 1'b1;
    read_direction_strobe = 1'b0;
    write_enable_n = 1'b1;
    dma_grant_n = 1'b1;
    register_select = 3'h0;
    data_in = 8'h00;
  end

  // ****************************************************************
  // One byte access; en selects the chip, dma uses the grant
  // ****************************************************************
  task automatic access(input logic en, input logic dma, input logic wr,
    input logic [2:0] s, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(negedge clk);
    chip_enable_n = !en;
    dma_grant_n = !dma;
    register_select = s;
    read_direction_strobe = wr ? dma : !dma;
    write_enable_n = !wr;
    data_in = wd;
    rd = 8'h00;
    if (wr)
      repeat (5) @(posedge clk);
    else
    begin
      // Outputs are looked at on the falling edge, where they are settled
      @(negedge clk);
      while (data_oe !== 1'b1 && n < 20)
      begin
        @(negedge clk);
        n++;
      end
      rd = data_out;
    end
    @(negedge clk);
    chip_enable_n = 1'b1;
    dma_grant_n = 1'b1;
    write_enable_n = 1'b1;
    read_direction_strobe = 1'b0;
    data_in = ~wd; // Released bus carries the complement of the written byte
    repeat (5) @(negedge clk);
  endtask : access
endmodule : host_agent
`default_nettype wire

// ---- verif/host_port_tb.sv ----
// Self-checking bench for the host parallel port
`timescale 1ns/1ns
`default_nettype none
module host_port_tb;
  import host_port_pkg::*;
  logic clk = 1'b0;
  logic reset;
  logic [COND_W-1:0] int_cond;
  logic rx_valid;
  logic [DATA_W-1:0] rx_data;
  logic tx_ready;
  logic chip_enable_n;
  logic read_direction_strobe;
  logic write_enable_n;
  logic dma_grant_n;
  logic [SEL_W-1:0] register_select;
  logic [DATA_W-1:0] data_in;
  logic [DATA_W-1:0] data_out;
  logic data_oe;
  logic dma_request_n;
  logic int_n_out;
  logic int_n_oe;
  logic rx_ready;
  logic tx_valid;
  logic [DATA_W-1:0] tx_data;
  logic [DATA_W-1:0] v;
  int bad_count = 0;
  int tests_run = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  host_port dut (.*);
  host_agent host (.*);

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic cb(input string w, input logic e, input logic g);
    chk(w, {7'h00, e}, {7'h00, g});
  endtask : cb

  task automatic rdc(input logic [2:0] s, input logic [7:0] e, input string w);
    host.access(1'b1, 1'b0, 1'b0, s, 8'h00, v);
    chk(w, e, v);
  endtask : rdc

  task automatic wrc(input logic [2:0] s, input logic [7:0] d);
    host.access(1'b1, 1'b0, 1'b1, s, d, v);
  endtask : wrc

  task automatic tally_and_finish;
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    int_cond = 8'h24;
    rdc(SEL_INT, 8'h24, "cond read");
    cb("int masked", 1'b0, int_n_oe);
    wrc(SEL_INT, 8'h04);
    cb("int on", 1'b1, int_n_oe);
    cb("int drive", 1'b0, int_n_out);
    wrc(3'h5, 8'h00);
    cb("reserved write", 1'b1, int_n_oe);
    rdc(3'h4, 8'h00, "reserved read");
    int_cond = 8'h20;
    repeat (2) @(negedge clk);
    cb("int off", 1'b0, int_n_oe);
  endtask : t_regs

  task automatic t_noce;
    host.access(1'b0, 1'b0, 1'b1, SEL_INT, 8'h20, v);
    cb("no ce write", 1'b0, int_n_oe);
    host.access(1'b0, 1'b0, 1'b0, SEL_INT, 8'h00, v);
    chk("no ce read", 8'h00, v);
  endtask : t_noce

  task automatic t_fifo;
    for (int i = 0; i < 8; i++)
    begin
      rx_valid = 1'b1;
      rx_data = 8'h10 + 8'(i);
      @(negedge clk);
    end
    cb("fifo full", 1'b0, rx_ready);
    rx_valid = 1'b0;
    rdc(SEL_STATUS, 8'h03, "status full");
    for (int i = 0; i < 8; i++)
      rdc(SEL_DATA, 8'h10 + 8'(i), "fifo head");
    rdc(SEL_DATA, 8'h00, "empty read");
    cb("fifo room", 1'b1, rx_ready);
  endtask : t_fifo

  task automatic t_dma;
    wrc(SEL_STATUS, 8'h01);
    cb("req empty", 1'b1, dma_request_n);
    rx_valid = 1'b1;
    rx_data = 8'hA5;
    @(negedge clk);
    rx_valid = 1'b0;
    repeat (3) @(negedge clk);
    cb("req in", 1'b0, dma_request_n);
    host.access(1'b0, 1'b1, 1'b0, SEL_INT, 8'h00, v);
    chk("dma read", 8'hA5, v);
    cb("req done", 1'b1, dma_request_n);
    tx_ready = 1'b0;
    wrc(SEL_STATUS, 8'h02);
    cb("req out", 1'b0, dma_request_n);
    host.access(1'b0, 1'b1, 1'b1, SEL_INT, 8'h3C, v);
    chk("dma write", 8'h3C, tx_data);
    cb("tx valid", 1'b1, tx_valid);
    rdc(SEL_STATUS, 8'h04, "status cmd out");
    wrc(SEL_DATA, 8'h5A);
    chk("cmd out write", 8'h5A, tx_data);
    tx_ready = 1'b1;
    repeat (3) @(negedge clk);
    cb("tx drained", 1'b0, tx_valid);
    cb("req again", 1'b0, dma_request_n);
    wrc(SEL_STATUS, 8'h00);
  endtask : t_dma

  task automatic t_mid_reset;
    int_cond = 8'h04;
    repeat (2) @(negedge clk);
    cb("int set", 1'b1, int_n_oe);
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    cb("int reset", 1'b0, int_n_oe);
    rdc(SEL_STATUS, 8'h00, "status reset");
  endtask : t_mid_reset

  // Main sequence
  initial
  begin
    reset = 1'b1;
    int_cond = 8'h00;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    cb("idle oe", 1'b0, data_oe);
    cb("idle req", 1'b1, dma_request_n);
    t_regs();
    t_noce();
    t_fifo();
    t_dma();
    t_mid_reset();
    tally_and_finish();
  end

  // Watchdog well past the expected run length
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : host_port_tb
`default_nettype wire
